// [dcsc_slew_ctrl.v]
`timescale 1ns/1ps
`default_nettype none
`include "dcsc_defs.vh"
// Functional notes
// RL1: short limit code 00=22,01=10,10=26,11=31 mA
// RL2: HART inject enable follows configuration bit 13
// RL3: output driver enabled only while bit 12
// RL4: rate field bits 11:8, 0000 fastest, 1111 slowest
// RL5: codes 1..3 give 200k, 153.8k, 131.1k Hz
// RL6: codes 4..7 give 115.9k to 25.8k Hz
// RL7: codes 8,A,B,C give 20.1k to 6.9k Hz
// RL8: step size is two to the code LSBs
// RL9: slewing active only while bit 4 set
// RL10: step toward target without overshoot, else immediate
// RL11: range codes 4..7 select current outputs
// RL12: range codes 0,3,8,9,B select voltage outputs
// RL13: range change forces code to clear level
// RL14: clear select bit picks zero or mid scale
// RL15: sixteen bit target code register at 0x05
module dcsc_slew_ctrl #(
  parameter DATA_W   = 16,
  parameter CLK_HZ   = `DCSC_CLK_HZ,
  parameter DIV_MAX  = 65535
) (
  input  wire                      clk_sys,
  input  wire                      rst,
  input  wire                      clk_en,
  input  wire [`DCSC_ADDR_W-1:0]   reg_addr,
  input  wire [15:0]               reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [15:0]               reg_rdata,
  output reg  [1:0]                short_limit_sel,
  output reg  [5:0]                short_limit_ma,
  output reg                       hart_inject_en,
  output reg                       output_drive_en,
  output reg                       range_is_current,
  output reg                       range_is_bipolar,
  output reg  [DATA_W-1:0]         active_code,
  output reg                       slew_busy
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // cycles per slew tick, rounded down to keep the rate at least nominal
  // the quotient is 32 bits wide and cut to the counter width on purpose
  function [16:0] rate_div;
    input [3:0] code;
    integer     hz;
    integer     cyc;
    begin
      case (code)
        4'h0: hz = `DCSC_HZ_0;
        4'h1: hz = `DCSC_HZ_1;
        4'h2: hz = `DCSC_HZ_2;
        4'h3: hz = `DCSC_HZ_3;
        4'h4: hz = `DCSC_HZ_4;
        4'h5: hz = `DCSC_HZ_5;
        4'h6: hz = `DCSC_HZ_6;
        4'h7: hz = `DCSC_HZ_7;
        4'h8: hz = `DCSC_HZ_8;
        4'h9: hz = `DCSC_HZ_9;
        4'hA: hz = `DCSC_HZ_A;
        4'hB: hz = `DCSC_HZ_B;
        4'hC: hz = `DCSC_HZ_C;
        4'hD: hz = `DCSC_HZ_D;
        4'hE: hz = `DCSC_HZ_E;
        default: hz = `DCSC_HZ_F;
      endcase
      cyc      = CLK_HZ / hz;
      rate_div = cyc[16:0];
    end
  endfunction

  // clear level picked by the select bit
  function [DATA_W-1:0] clear_code;
    input sel;
    begin
      if (sel) begin
        clear_code = `DCSC_MID_CODE;
      end else begin
        clear_code = `DCSC_ZERO_CODE;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [15:0]        cfg_r;
  reg                clear_level_sel;
  reg  [DATA_W-1:0]  target_r;
  reg  [16:0]        div_cnt_r;
  reg                tick_r;

  wire [3:0]         slew_tick_rate;
  wire [2:0]         slew_step_size;
  wire               slew_en;
  wire [3:0]         range_sel;
  wire [3:0]         new_range;
  wire               cfg_wr;
  wire               range_change;
  wire [DATA_W:0]    step_val;
  wire [DATA_W:0]    up_sum;
  wire [DATA_W:0]    dn_diff;

  assign slew_tick_rate = cfg_r[`DCSC_RATE_HI:`DCSC_RATE_LO];     // see RL4
  assign slew_step_size = cfg_r[`DCSC_STEP_HI:`DCSC_STEP_LO];
  assign slew_en        = cfg_r[`DCSC_SLEWEN_BIT];
  assign range_sel      = cfg_r[`DCSC_RANGE_HI:`DCSC_RANGE_LO];
  assign new_range      = reg_wdata[`DCSC_RANGE_HI:`DCSC_RANGE_LO];
  assign cfg_wr         = reg_wr && (reg_addr == `DCSC_ADDR_CFG);
  assign range_change   = cfg_wr && (new_range != range_sel);    // see RL13

  // step is two to the code, held one bit wider for overshoot checks
  assign step_val = {{(DATA_W){1'b0}}, 1'b1} << slew_step_size;  // see RL8
  assign up_sum   = {1'b0, active_code} + step_val;
  assign dn_diff  = {1'b0, active_code} - step_val;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_r           <= `DCSC_CFG_RESET;
      clear_level_sel <= 1'b0;
      target_r        <= `DCSC_CODE_RESET;
    end else if (clk_en) begin
      if (cfg_wr) begin
        cfg_r <= reg_wdata;
      end
      if (reg_wr && (reg_addr == `DCSC_ADDR_CLRSEL)) begin
        clear_level_sel <= reg_wdata[`DCSC_CLR_LEVEL_BIT];     // see RL14
      end
      // a range change overrides a pending target with the clear level
      if (range_change) begin
        target_r <= clear_code(clear_level_sel);               // see RL13
      end else if (reg_wr && (reg_addr == `DCSC_ADDR_CODE)) begin
        target_r <= reg_wdata[DATA_W-1:0];                     // see RL15
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      if (reg_rd) begin
        if (reg_addr == `DCSC_ADDR_CFG) begin
          reg_rdata <= cfg_r;
        end else if (reg_addr == `DCSC_ADDR_CODE) begin
          reg_rdata <= target_r;
        end else if (reg_addr == `DCSC_ADDR_CLRSEL) begin
          reg_rdata <= {6'h00, clear_level_sel, 9'h000};
        end else begin
          reg_rdata <= 16'h0000;
        end
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // slew tick divider
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_cnt_r <= 17'h00000;
      tick_r    <= 1'b0;
    end else if (clk_en) begin
      if (!slew_en || cfg_wr) begin
        div_cnt_r <= 17'h00000;
        tick_r    <= 1'b0;
      end else if (div_cnt_r >= rate_div(slew_tick_rate) - 17'h00001) begin
        div_cnt_r <= 17'h00000;                                // see RL5
        tick_r    <= 1'b1;                                     // see RL6
      end else begin
        div_cnt_r <= div_cnt_r + 17'h00001;                    // see RL7
        tick_r    <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // output code stepping
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      active_code <= `DCSC_CODE_RESET;
      slew_busy   <= 1'b0;
    end else if (clk_en) begin
      slew_busy <= slew_en && (active_code != target_r);
      if (!slew_en) begin
        active_code <= target_r;                               // see RL9
      end else if (tick_r) begin
        // clamp the last step onto the target
        if (active_code < target_r) begin
          if (up_sum >= {1'b0, target_r}) begin
            active_code <= target_r;                           // see RL10
          end else begin
            active_code <= up_sum[DATA_W-1:0];
          end
        end else if (active_code > target_r) begin
          if (dn_diff[DATA_W] || (dn_diff <= {1'b0, target_r})) begin
            active_code <= target_r;
          end else begin
            active_code <= dn_diff[DATA_W-1:0];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // analog stage controls
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      short_limit_sel  <= 2'h0;
      short_limit_ma   <= 6'h16;
      hart_inject_en   <= 1'b0;
      output_drive_en  <= 1'b0;
      range_is_current <= 1'b0;
      range_is_bipolar <= 1'b0;
    end else if (clk_en) begin
      short_limit_sel <= cfg_r[`DCSC_SHORT_LIM_HI:`DCSC_SHORT_LIM_LO];
      case (cfg_r[`DCSC_SHORT_LIM_HI:`DCSC_SHORT_LIM_LO])
        2'h0: short_limit_ma <= 6'h16;                         // see RL1
        2'h1: short_limit_ma <= 6'h0A;
        2'h2: short_limit_ma <= 6'h1A;
        default: short_limit_ma <= 6'h1F;
      endcase
      hart_inject_en   <= cfg_r[`DCSC_HART_BIT];               // see RL2
      output_drive_en  <= cfg_r[`DCSC_OUTEN_BIT];              // see RL3
      range_is_current <= (range_sel[3:2] == 2'h1);            // see RL11
      case (range_sel)
        4'h1, 4'h2, 4'h3, 4'h7, 4'hA, 4'hB, 4'hF: range_is_bipolar <= 1'b1;
        default: range_is_bipolar <= 1'b0;                     // see RL12
      endcase
    end
  end

endmodule
`default_nettype wire

// [dcsc_defs.vh]
`ifndef DCSC_DEFS_VH
`define DCSC_DEFS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define DCSC_ADDR_W          4
`define DCSC_ADDR_CLRSEL     4'h3
`define DCSC_ADDR_CFG        4'h4
`define DCSC_ADDR_CODE       4'h5

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DCSC_CFG_RESET       16'h0000
`define DCSC_CODE_RESET      16'h0000
`define DCSC_CLRSEL_RESET    16'h0000
`define DCSC_CLRSEL_MASK     16'h0200
`define DCSC_CLR_LEVEL_BIT   9
`define DCSC_SHORT_LIM_HI    15
`define DCSC_SHORT_LIM_LO    14
`define DCSC_HART_BIT        13
`define DCSC_OUTEN_BIT       12
`define DCSC_RATE_HI         11
`define DCSC_RATE_LO         8
`define DCSC_STEP_HI         7
`define DCSC_STEP_LO         5
`define DCSC_SLEWEN_BIT      4
`define DCSC_RANGE_HI        3
`define DCSC_RANGE_LO        0
`define DCSC_ZERO_CODE       16'h0000
`define DCSC_MID_CODE        16'h8000

// ----------------------------------------------------------------
// slew tick rates in Hz and clock
// ----------------------------------------------------------------
`define DCSC_CLK_HZ          200000000
`define DCSC_HZ_0            258065
`define DCSC_HZ_1            200000
`define DCSC_HZ_2            153845
`define DCSC_HZ_3            131145
`define DCSC_HZ_4            115940
`define DCSC_HZ_5            69565
`define DCSC_HZ_6            37560
`define DCSC_HZ_7            25805
`define DCSC_HZ_8            20150
`define DCSC_HZ_9            20150
`define DCSC_HZ_A            10295
`define DCSC_HZ_B            8280
`define DCSC_HZ_C            6900
`define DCSC_HZ_D            4240
`define DCSC_HZ_E            4240
`define DCSC_HZ_F            3300

`endif

// [dcsc_slew_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcsc_defs.vh"
// ------------------------------------------------
// port checker for the slew controller
// ------------------------------------------------
module dcsc_slew_asserts (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [1:0]  short_limit_sel,
  input wire logic [5:0]  short_limit_ma,
  input wire logic        hart_inject_en,
  input wire logic        output_drive_en,
  input wire logic        range_is_current,
  input wire logic        range_is_bipolar,
  input wire logic        slew_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // configuration write taken at this edge
  wire cfg_wr = reg_wr && clk_en && (reg_addr == `DCSC_ADDR_CFG);
  rd_idle_zero_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  limit_decode_a: assert property (short_limit_ma == (short_limit_sel == 2'h0 ? 6'h16 :
    short_limit_sel == 2'h1 ? 6'h0A : short_limit_sel == 2'h2 ? 6'h1A : 6'h1F))
    else $error("short limit decode wrong");
  limit_follow_a: assert property (cfg_wr |-> ##2 short_limit_sel == $past(reg_wdata[15:14], 2))
    else $error("short limit select not taken");
  hart_follow_a: assert property (cfg_wr |-> ##2 hart_inject_en == $past(reg_wdata[13], 2))
    else $error("hart enable not taken");
  drive_follow_a: assert property (cfg_wr |-> ##2 output_drive_en == $past(reg_wdata[12], 2))
    else $error("output enable not taken");
  current_decode_a: assert property (cfg_wr |-> ##2
    range_is_current == ($past(reg_wdata[3:2], 2) == 2'h1))
    else $error("current range decode wrong");
  bipolar_decode_a: assert property (cfg_wr |-> ##2
    range_is_bipolar == ($past(reg_wdata[3:0], 2) inside {4'h1, 4'h2, 4'h3, 4'h7, 4'hA, 4'hB, 4'hF}))
    else $error("bipolar range decode wrong");
  clrsel_read_a: assert property (reg_rd && reg_addr == `DCSC_ADDR_CLRSEL |=>
    (reg_rdata & ~`DCSC_CLRSEL_MASK) == 16'h0000)
    else $error("clear select reads unused bits");
  cover property (cfg_wr ##2 range_is_current);
  cover property ($rose(slew_busy));
  cover property (reg_rd && reg_addr == `DCSC_ADDR_CODE);
endmodule
bind dcsc_slew_ctrl dcsc_slew_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .short_limit_sel(short_limit_sel), .short_limit_ma(short_limit_ma),
  .hart_inject_en(hart_inject_en), .output_drive_en(output_drive_en),
  .range_is_current(range_is_current), .range_is_bipolar(range_is_bipolar),
  .slew_busy(slew_busy));
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcsc_defs.vh"
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire  [15:0] reg_rdata, active_code;
  wire  [1:0]  short_limit_sel;
  wire  [5:0]  short_limit_ma;
  wire         hart_inject_en, output_drive_en, range_is_current, range_is_bipolar, slew_busy;
  int          err_count = 0;
  int          compares = 0;
  logic [15:0] d;
  // slow clock setting shortens every tick period
  dcsc_slew_ctrl #(.CLK_HZ(2000000)) uut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .short_limit_sel(short_limit_sel), .short_limit_ma(short_limit_ma),
    .hart_inject_en(hart_inject_en), .output_drive_en(output_drive_en),
    .range_is_current(range_is_current), .range_is_bipolar(range_is_bipolar),
    .active_code(active_code), .slew_busy(slew_busy));
  initial forever #2.5 clk_sys = ~clk_sys;
  // ------------------------------------------------
  // bus and compare helpers
  // ------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask
  // counts cycles until the output code moves, bounded
  task automatic wait_chg(output logic [15:0] dt);
    logic [15:0] old;
    old = active_code;
    dt = 16'h0000;
    while (active_code === old && dt < 16'h0BB8) begin
      @(negedge clk_sys);
      dt++;
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_reset;
    chk({10'h000, short_limit_ma}, 16'h0016, "limit at reset");
    chk({hart_inject_en, output_drive_en, slew_busy}, 3'h0, "enables at reset");
    rd(`DCSC_ADDR_CODE, d);
    chk(d, 16'h0000, "code reset");
    $display("test reset done");
  endtask
  task automatic t_fields;
    logic [15:0] ma [4] = '{16'h0016, 16'h000A, 16'h001A, 16'h001F};
    for (int i = 0; i < 4; i++) begin
      wr(`DCSC_ADDR_CFG, {i[1:0], i[0], ~i[0], 12'h000});
      chk({10'h000, short_limit_ma}, ma[i], "limit");
      chk({hart_inject_en, output_drive_en}, {i[0], ~i[0]}, "hart and drive");
    end
    $display("test fields done");
  endtask
  task automatic t_ranges;
    logic [3:0] r [9] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB};
    for (int i = 0; i < 9; i++) begin
      wr(`DCSC_ADDR_CFG, {12'h000, r[i]});
      chk({range_is_current, range_is_bipolar}, {r[i][3:2] == 2'h1, r[i] inside {3, 7, 11}},
        "range kind");
    end
    $display("test ranges done");
  endtask
  task automatic t_clear;
    wr(`DCSC_ADDR_CLRSEL, 16'hFFFF);
    rd(`DCSC_ADDR_CLRSEL, d);
    chk(d, 16'h0200, "clear select");
    wr(`DCSC_ADDR_CODE, 16'h1234);
    chk(active_code, 16'h1234, "immediate code");
    wr(`DCSC_ADDR_CFG, 16'h0004);
    chk(active_code, 16'h8000, "mid clear");
    rd(`DCSC_ADDR_CODE, d);
    chk(d, 16'h8000, "target cleared");
    wr(`DCSC_ADDR_CLRSEL, 16'h0000);
    wr(`DCSC_ADDR_CFG, 16'h0003);
    chk(active_code, 16'h0000, "zero clear");
    rd(4'hF, d);
    chk(d, 16'h0000, "unmapped read");
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(`DCSC_ADDR_CODE, 16'h5555);
    chk(active_code, 16'h0000, "frozen code");
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(`DCSC_ADDR_CODE, d);
    chk(d, 16'h0000, "frozen write ignored");
    $display("test clear done");
  endtask
  task automatic t_slew;
    logic [15:0] dt, v;
    logic [15:0] ex [3] = '{16'h0004, 16'h0008, 16'h000A};
    int hz [13] = '{258065, 200000, 153845, 131145, 115940, 69565, 37560, 25805, 20150,
      10295, 8280, 6900, 3300};
    logic [3:0] cd [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10, 11, 12, 15};
    wr(`DCSC_ADDR_CFG, 16'h0053);
    wr(`DCSC_ADDR_CODE, 16'h000A);
    for (int k = 0; k < 3; k++) begin
      wait_chg(dt);
      chk(active_code, ex[k], "slew step");
      if (k == 0) chk({15'h0000, slew_busy}, 16'h0001, "busy while slewing");
      if (k > 0) chk(dt, 16'(2000000 / hz[0]), "tick period");
    end
    wr(`DCSC_ADDR_CODE, 16'hFFFF);
    for (int j = 0; j < 13; j++) begin
      wr(`DCSC_ADDR_CFG, {4'h0, cd[j], 8'hF3});
      wait_chg(dt);
      v = active_code;
      wait_chg(dt);
      chk(dt, 16'(2000000 / hz[j]), "rate period");
      chk(active_code - v, 16'h0080, "large step");
    end
    wr(`DCSC_ADDR_CFG, 16'h0003);
    chk(active_code, 16'hFFFF, "slew off jumps");
    chk({15'h0000, slew_busy}, 16'h0000, "idle with slew off");
    $display("test slew done");
  endtask
  // ------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    t_reset;
    t_fields;
    t_ranges;
    t_clear;
    t_slew;
    stop_test;
  end
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
endmodule
`default_nettype wire
